// *** hw/ebls_pkg.sv ***
// Shared types and constants for the external bus byte-lane steering block
package ebls_pkg;

    // ------------------------------------------------------------------
    // System transfer sizes
    // ------------------------------------------------------------------
    localparam logic [2:0] EBLS_SIZE_BYTE  = 3'h0;
    localparam logic [2:0] EBLS_SIZE_HALF  = 3'h1;
    localparam logic [2:0] EBLS_SIZE_WORD  = 3'h2;
    localparam logic [2:0] EBLS_SIZE_DWORD = 3'h3;

    // ------------------------------------------------------------------
    // Active-low lane select patterns, 32-bit bus
    // ------------------------------------------------------------------
    localparam logic [3:0] EBLS_BLS_ALL    = 4'h0;
    localparam logic [3:0] EBLS_BLS_UPHALF = 4'h3;
    localparam logic [3:0] EBLS_BLS_LOHALF = 4'hC;
    localparam logic [3:0] EBLS_BLS_NONE   = 4'hF;
    // 8-bit bus: lane 0 active, unused lanes masked
    localparam logic [3:0] EBLS_BLS_NARROW = 4'hE;

    // ------------------------------------------------------------------
    // Beat counts and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] EBLS_BEATS_ONE   = 4'h1;
    localparam logic [3:0] EBLS_BEATS_TWO   = 4'h2;
    localparam logic [3:0] EBLS_BEATS_FOUR  = 4'h4;
    localparam logic [3:0] EBLS_BEATS_EIGHT = 4'h8;
    localparam logic [2:0] EBLS_ADDR_TOP    = 3'h7;
    localparam logic [2:0] EBLS_ADDR_RST    = 3'h0;
    localparam logic [31:0] EBLS_DATA32_RST = 32'h0000_0000;
    localparam logic [63:0] EBLS_DATA64_RST = 64'h0000_0000_0000_0000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        readBe8;   // 1: big-endian read, 8-bit bus
        logic [2:0]  size;
        logic [2:0]  addr;
        logic [63:0] wdata;
    } ebls_req_t;

    typedef struct packed {
        logic [2:0]  addr;
        logic [3:0]  blsN;
        logic [31:0] data;
    } ebls_beat_t;

    typedef enum logic [1:0] {
        EBLS_IDLE,
        EBLS_XFER,
        EBLS_RESP
    } ebls_state_t;

endpackage

// *** hw/ebls_write_steer.sv ***
// Little-endian write lane steering onto a 32-bit external bus
`timescale 1ns/1ps
module ebls_write_steer
    import ebls_pkg::*;
(
    input  wire logic [2:0]  size,
    input  wire logic [2:0]  addr,
    input  wire logic        upperWord,
    input  wire logic [63:0] wdata,
    output logic      [3:0]  blsN,
    output logic      [31:0] laneData
);

    wire logic [31:0] wordSel;
    wire logic [3:0]  byteBls;
    wire logic [3:0]  halfBls;
    wire logic [31:0] laneMask;

    // ------------------------------------------------------------------
    // Word choice and lane patterns
    // ------------------------------------------------------------------
    assign wordSel = upperWord ? wdata[63:32] : wdata[31:0];
    assign halfBls = addr[1] ? EBLS_BLS_UPHALF : EBLS_BLS_LOHALF;
    assign byteBls = ~(4'h1 << addr[1:0]);

    always_comb begin
        unique case (size)
            EBLS_SIZE_BYTE: blsN = byteBls;
            EBLS_SIZE_HALF: blsN = halfBls;
            default:        blsN = EBLS_BLS_ALL;
        endcase
    end

    // Masked lanes carry zero; a zero select enables its lane
    assign laneMask = {{8{~blsN[3]}}, {8{~blsN[2]}},
                       {8{~blsN[1]}}, {8{~blsN[0]}}};
    assign laneData = wordSel & laneMask;

endmodule

// *** hw/ebls_lane_steer.sv ***
// Byte-lane steering sequencer between a 64-bit system word and a narrow bus
`timescale 1ns/1ps
// What this block does
// - LE word write, address bit 2 set: bits 63:32 out, all four lanes on.
// - LE word write, address bit 2 clear: bits 31:0 out, all lanes on.
// - LE doubleword write: two transfers, upper then lower, all lanes on.
// - LE halfword write, address bit 1 set: lanes 31:16, selects 0011.
// - LE halfword write, address bit 1 clear: lanes 15:0, selects 1100.
// - LE byte write at 11: lane 31:24, selects 0111.
// - LE byte write at 10: lane 23:16, selects 1011.
// - LE byte write at 01: lane 15:8, selects 1101.
// - LE byte write at 00: lane 7:0, selects 1110.
// - BE doubleword read, 8-bit bus: eight bytes, addresses 111 down to 000.
// - BE word read, 8-bit bus: four bytes, x11 down to x00, select 0.
// - BE halfword read, 8-bit bus: two bytes at that halfword's addresses.
// - BE upper-word bytes 111..100 land in lanes 39:32 up to 63:56.
// - BE lower-word bytes 011..000 land in lanes 7:0 up to 31:24.
// - BE byte read: select held 0, address taken from system address.
module ebls_lane_steer
    import ebls_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    // System request side
    input  wire logic        reqValid,
    output logic             reqReady,
    input  wire ebls_req_t   req,
    output logic             rspValid,
    output logic             rspError,
    output logic      [63:0] rspData,
    // External memory side
    output logic             extValid,
    output logic             extWrite,
    input  wire logic        extAck,
    output logic      [2:0]  external_address_out,
    output logic      [3:0]  byte_lane_select_n,
    output logic      [31:0] external_data_bus_out,
    output logic             external_data_bus_oe,
    input  wire logic [31:0] external_data_bus_in
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // System byte lane of a big-endian byte read from the 8-bit bus
    function automatic logic [2:0] beLane(input logic [2:0] a);
        beLane = {a[2], ~a[1], ~a[0]};
    endfunction

    // First external address of a big-endian read sequence
    function automatic logic [2:0] beStart(input logic [2:0] sz,
                                           input logic [2:0] a);
        unique case (sz)
            EBLS_SIZE_DWORD: beStart = EBLS_ADDR_TOP;
            EBLS_SIZE_WORD:  beStart = {a[2], 2'b11};
            EBLS_SIZE_HALF:  beStart = {a[2:1], 1'b1};
            default:         beStart = a;
        endcase
    endfunction

    // Number of external transfers for a request
    function automatic logic [3:0] beatCount(input logic rd,
                                             input logic [2:0] sz);
        if (rd) begin
            unique case (sz)
                EBLS_SIZE_DWORD: beatCount = EBLS_BEATS_EIGHT;
                EBLS_SIZE_WORD:  beatCount = EBLS_BEATS_FOUR;
                EBLS_SIZE_HALF:  beatCount = EBLS_BEATS_TWO;
                default:         beatCount = EBLS_BEATS_ONE;
            endcase
        end else begin
            if (sz == EBLS_SIZE_DWORD) begin
                beatCount = EBLS_BEATS_TWO;
            end else begin
                beatCount = EBLS_BEATS_ONE;
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ebls_state_t state;
    ebls_state_t next_state;
    ebls_req_t   held;
    logic [3:0]  beatsLeft;
    logic [63:0] readData;
    logic        errFlag;
    ebls_beat_t  beat;

    // ------------------------------------------------------------------
    // Request acceptance and sequence decode
    // ------------------------------------------------------------------
    wire logic        inIdle;
    wire logic        inXfer;
    wire logic        take;
    wire logic        sizeBad;
    wire logic        beatDone;
    wire logic        lastBeat;
    wire ebls_req_t   src;
    wire logic        srcUpper;
    wire logic [2:0]  nextReadAddr;
    wire logic [3:0]  wrBlsN;
    wire logic [31:0] wrData;
    wire ebls_beat_t  next_beat;
    wire logic [2:0]  capLane;

    assign inIdle   = (state == EBLS_IDLE);
    assign inXfer   = (state == EBLS_XFER);
    assign reqReady = inIdle;
    assign take     = inIdle & reqValid;
    assign sizeBad  = req.size[2];
    assign beatDone = inXfer & extAck;
    assign lastBeat = (beatsLeft == EBLS_BEATS_ONE);

    // Steering source: incoming request for beat one, held one later
    assign src = inIdle ? req : held;

    // Doubleword write sends upper word first, then lower
    assign srcUpper = inIdle
                    ? ((req.size == EBLS_SIZE_DWORD) | req.addr[2])
                    : 1'b0;

    // Read address walks downward from the sequence start
    assign nextReadAddr = inIdle ? beStart(req.size, req.addr)
                                 : beat.addr - 3'h1;

    ebls_write_steer u_write_steer (
        .size      (src.size),
        .addr      (src.addr),
        .upperWord (srcUpper),
        .wdata     (src.wdata),
        .blsN      (wrBlsN),
        .laneData  (wrData)
    );

    // 32-bit bus carries the word select in address bit 2
    assign next_beat.addr = src.readBe8 ? nextReadAddr
                                        : {srcUpper, 2'b00};
    assign next_beat.blsN = src.readBe8 ? EBLS_BLS_NARROW
                                        : wrBlsN;
    assign next_beat.data = src.readBe8 ? EBLS_DATA32_RST : wrData;

    assign capLane = beLane(beat.addr);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            EBLS_IDLE: begin
                if (reqValid) begin
                    next_state = sizeBad ? EBLS_RESP : EBLS_XFER;
                end
            end
            EBLS_XFER: begin
                if (extAck && lastBeat) begin
                    next_state = EBLS_RESP;
                end
            end
            EBLS_RESP: begin
                next_state = EBLS_IDLE;
            end
            default: begin
                next_state = EBLS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state <= EBLS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Request hold and beat counter
    always_ff @(posedge clock) begin
        if (srst) begin
            held      <= '0;
            beatsLeft <= 4'h0;
            errFlag   <= 1'b0;
        end else if (take) begin
            held      <= req;
            beatsLeft <= beatCount(req.readBe8, req.size);
            errFlag   <= sizeBad;
        end else if (beatDone) begin
            beatsLeft <= beatsLeft - 4'h1;
        end
    end

    // Registered external beat: loaded on legal accept and on each ack but the last
    always_ff @(posedge clock) begin
        if (srst) begin
            beat <= '{addr: EBLS_ADDR_RST, blsN: EBLS_BLS_NONE,
                      data: EBLS_DATA32_RST};
        end else if ((take && !sizeBad) || (beatDone && !lastBeat)) begin
            beat <= next_beat;
        end else if (beatDone || take) begin
            beat.blsN <= EBLS_BLS_NONE;
            beat.data <= EBLS_DATA32_RST;
        end
    end

    // ------------------------------------------------------------------
    // Read assembly: each byte lands in its big-endian lane
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            readData <= EBLS_DATA64_RST;
        end else if (take) begin
            readData <= EBLS_DATA64_RST;
        end else if (beatDone && held.readBe8) begin
            readData[capLane*8 +: 8] <= external_data_bus_in[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign extValid              = inXfer;
    assign extWrite              = inXfer & ~held.readBe8;
    assign external_address_out  = beat.addr;
    assign byte_lane_select_n    = inXfer ? beat.blsN : EBLS_BLS_NONE;
    assign external_data_bus_out = beat.data;
    assign external_data_bus_oe  = inXfer & ~held.readBe8;
    assign rspValid              = (state == EBLS_RESP);
    assign rspError              = rspValid & errFlag;
    assign rspData               = readData;

endmodule

// *** verif/ebls_checker.sv ***
// Port-level assertions for the byte-lane steering block
`timescale 1ns/1ps
module ebls_checker
    import ebls_pkg::*;
(
    input wire logic        clock,
    input wire logic        srst,
    input wire logic        reqValid,
    input wire logic        reqReady,
    input wire ebls_req_t   req,
    input wire logic        rspValid,
    input wire logic        rspError,
    input wire logic [63:0] rspData,
    input wire logic        extValid,
    input wire logic        extWrite,
    input wire logic        extAck,
    input wire logic [2:0]  external_address_out,
    input wire logic [3:0]  byte_lane_select_n,
    input wire logic [31:0] external_data_bus_out,
    input wire logic        external_data_bus_oe,
    input wire logic [31:0] external_data_bus_in
);
    logic [2:0] sizeQ, mskQ, expAddr;
    logic       readQ;
    logic [3:0] expBls;
    wire        take = reqValid && reqReady;
    wire  [2:0] msk  = req.size[1] ? {req.size[0], 2'b11}
                     : {2'h0, req.size[0]};
    wire  [3:0] blsW = req.size[1] ? 4'h0 : req.size[0]
                     ? (req.addr[1] ? 4'h3 : 4'hC) : ~(4'h1 << req.addr[1:0]);
    wire        lastBeat = readQ ? (external_address_out & mskQ) == 3'h0
                         : (sizeQ != 3'h3 || external_address_out == 3'h0);
    always_ff @(posedge clock) begin
        if (take) begin
            sizeQ   <= req.size;
            mskQ    <= msk;
            readQ   <= req.readBe8;
            // Doubleword write opens on the upper word whatever bit 2 is
            expAddr <= req.readBe8 ? (req.addr | msk)
                     : {req.addr[2] | (req.size == 3'h3), 2'b00};
            expBls  <= req.readBe8 ? 4'hE : blsW;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence takeLegal; take && !req.size[2]; endsequence
    sequence lastAck; extValid && extAck && lastBeat; endsequence
    first_beat_a: assert property (
        takeLegal |=> extValid && external_address_out == expAddr
                      && byte_lane_select_n == expBls)
        else $error("first beat address or selects wrong");
    sel_hold_a: assert property (
        extValid |-> byte_lane_select_n == expBls)
        else $error("lane selects changed within a transfer");
    idle_mask_a: assert property (
        !extValid |-> byte_lane_select_n == 4'hF)
        else $error("lane selected while idle");
    oe_write_a: assert property (
        external_data_bus_oe == (extValid && extWrite)
        && extWrite == (extValid && !readQ))
        else $error("output enable does not follow write beat");
    rd_step_a: assert property (
        extValid && readQ && extAck && !lastBeat |=> extValid
        && external_address_out == $past(external_address_out) - 3'h1)
        else $error("read address did not step down by one");
    dw_split_a: assert property (
        extValid && !readQ && extAck && !lastBeat |=> extValid
        && external_address_out == 3'h0 && byte_lane_select_n == 4'h0)
        else $error("second doubleword beat wrong");
    done_pulse_a: assert property (
        lastAck |=> rspValid && !extValid ##1 !rspValid)
        else $error("completion pulse missing after last beat");
    beat_hold_a: assert property (
        extValid && !extAck |=> $stable(external_address_out)
        && $stable(external_data_bus_out))
        else $error("beat changed before acknowledge");
    bad_size_a: assert property (
        take && req.size[2] |=> rspValid && rspError && !extValid)
        else $error("illegal size not refused");
endmodule

// *** verif/ebls_mem_model.sv ***
// Behavioural static memory on the narrow external bus
`timescale 1ns/1ps
module ebls_mem_model (
    input  wire logic        clock,
    input  wire logic        extValid,
    input  wire logic        extWrite,
    input  wire logic [2:0]  addr,
    input  wire logic [2:0]  waitCycles,
    output logic             extAck,
    output logic      [31:0] dataIn
);
    logic [2:0]  cnt   = 3'h0;
    logic [31:0] lastQ = 32'h0;
    wire  [7:0]  rdByte = {addr, ~addr, 2'b10};
    assign extAck = extValid && (cnt == waitCycles);
    // Data only while acking, otherwise the bus drifts
    assign dataIn = (extAck && !extWrite) ? {{3{~rdByte}}, rdByte} : ~lastQ;
    always @(posedge clock) begin
        cnt   <= (extValid && !extAck) ? cnt + 3'h1 : 3'h0;
        lastQ <= dataIn;
    end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the byte-lane steering block
`timescale 1ns/1ps
module tb
    import ebls_pkg::*;
;
    logic        clock, srst, reqValid, reqReady, rspValid, rspError;
    logic        extValid, extWrite, extAck, oe;
    ebls_req_t   req;
    logic [63:0] rspData;
    logic [2:0]  extAddr, memWait;
    logic [3:0]  bls;
    logic [31:0] dOut, dIn;
    int          num_errors = 0;
    int          n_tests    = 0;
    ebls_beat_t  seen[$];

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    ebls_lane_steer u_dut (.clock(clock), .srst(srst), .reqValid(reqValid),
        .reqReady(reqReady), .req(req), .rspValid(rspValid),
        .rspError(rspError), .rspData(rspData), .extValid(extValid),
        .extWrite(extWrite), .extAck(extAck), .external_address_out(extAddr),
        .byte_lane_select_n(bls), .external_data_bus_out(dOut),
        .external_data_bus_oe(oe), .external_data_bus_in(dIn));
    ebls_mem_model u_mem (.clock(clock), .extValid(extValid),
        .extWrite(extWrite), .addr(extAddr), .waitCycles(memWait),
        .extAck(extAck), .dataIn(dIn));
    always @(posedge clock) begin
        if (extValid === 1'b1 && extAck === 1'b1)
            seen.push_back('{extAddr, bls, extWrite ? dOut : 32'h0});
    end

    task automatic chk(input string what, input logic [63:0] got,
                       input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(input logic rd, input logic [2:0] sz,
                        input logic [2:0] a, input logic [63:0] wd);
        ebls_beat_t  exp[$];
        logic [63:0] expData;
        logic [31:0] w, m;
        logic [3:0]  s;
        logic [2:0]  b;
        int          k;
        expData = 64'h0;
        w = a[2] ? wd[63:32] : wd[31:0];
        m = sz[1] ? 32'hFFFF_FFFF : sz[0] ? (a[1] ? 32'hFFFF_0000
            : 32'h0000_FFFF) : 32'h0000_00FF << (8 * a[1:0]);
        for (k = 0; k < 4; k++) s[k] = ~|m[8*k +: 8];
        if (sz[2]) begin
        end else if (rd) begin
            b = a | 3'((1 << sz) - 1);
            for (k = 0; k < (1 << sz); k++) begin
                exp.push_back('{b, 4'hE, 32'h0});
                expData[8 * {b[2], ~b[1:0]} +: 8] = {b, ~b, 2'b10};
                b = b - 3'h1;
            end
        end else if (sz == 3'h3) begin
            exp.push_back('{3'h4, 4'h0, wd[63:32]});
            exp.push_back('{3'h0, 4'h0, wd[31:0]});
        end else exp.push_back('{{a[2], 2'b00}, s, w & m});
        seen.delete();
        @(negedge clock);
        chk("reqReady", reqReady, 1'b1);
        reqValid = 1'b1;
        req = '{rd, sz, a, wd};
        @(negedge clock);
        reqValid = 1'b0;
        for (k = 0; k < 200 && rspValid !== 1'b1; k++) @(negedge clock);
        chk("rspValid", rspValid, 1'b1);
        chk("rspError", rspError, sz[2]);
        chk("rspData", rspData, expData);
        chk("beats", seen.size(), exp.size());
        foreach (exp[i]) begin
            if (!rd) chk("bt", seen[i], exp[i]);
            else chk("bt", seen[i], exp[i]);
        end
    endtask

    task automatic t_write_all;
        memWait = 3'h1;
        for (int s = 0; s < 4; s++)
            for (int a = 0; a < 8; a++)
                xfer(1'b0, 3'(s), 3'(a), 64'h8877_6655_4433_2211);
    endtask

    task automatic t_read_all(input logic [2:0] slow);
        memWait = slow;
        for (int s = 0; s < 4; s++)
            for (int a = 0; a < 8; a++)
                xfer(1'b1, 3'(s), 3'(a), 64'h0);
    endtask

    task automatic t_illegal;
        xfer(1'b0, 3'h4, 3'h5, 64'h1);
        xfer(1'b1, 3'h7, 3'h2, 64'h0);
    endtask

    task automatic close_out;
        $display("Checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        srst = 1'b1;
        reqValid = 1'b0;
        req = '0;
        memWait = 3'h0;
        repeat (8) @(negedge clock);
        srst = 1'b0;
        t_write_all();
        t_read_all(3'h0);
        t_read_all(3'h3);
        t_illegal();
        close_out();
    end
    initial begin
        #100us;
        num_errors++;
        $display("[ERR] watchdog expected finish seen hang");
        close_out();
    end
endmodule

bind ebls_lane_steer ebls_checker u_chk (.clock(clock), .srst(srst),
    .reqValid(reqValid), .reqReady(reqReady), .req(req),
    .rspValid(rspValid), .rspError(rspError), .rspData(rspData),
    .extValid(extValid), .extWrite(extWrite), .extAck(extAck),
    .external_address_out(external_address_out),
    .byte_lane_select_n(byte_lane_select_n),
    .external_data_bus_out(external_data_bus_out),
    .external_data_bus_oe(external_data_bus_oe),
    .external_data_bus_in(external_data_bus_in));
